// file: shared/acd_pkg.sv
// Package: configuration word layout, modes and timing for the converter control block
package acd_pkg;
   // Word framing
   localparam int unsigned ACD_WORD_BITS = 12;
   localparam int unsigned ACD_FRAME_EDGES = 16;
   localparam logic [4:0] ACD_LAST_LOAD_EDGE = 5'h0c;
   localparam logic [4:0] ACD_FRAME_EDGES_5 = 5'h10;
   // Field positions in the configuration word
   localparam int unsigned ACD_BIT_WRITE = 11;
   localparam int unsigned ACD_BIT_SEQ = 10;
   localparam int unsigned ACD_BIT_ADDR_HI = 8;
   localparam int unsigned ACD_BIT_ADDR_LO = 6;
   localparam int unsigned ACD_BIT_PM_HI = 5;
   localparam int unsigned ACD_BIT_PM_LO = 4;
   localparam int unsigned ACD_BIT_MASK_SEL = 3;
   localparam int unsigned ACD_BIT_RANGE = 1;
   localparam int unsigned ACD_BIT_CODING = 0;
   // Reset values of applied settings
   localparam logic [1:0] ACD_PM_RESET = 2'h3;
   localparam logic [2:0] ACD_CHAN_RESET = 3'h0;
   localparam logic ACD_RANGE_RESET = 1'b0;
   localparam logic ACD_CODING_RESET = 1'b0;
   localparam logic [1:0] ACD_SEQ_RESET = 2'h0;
   // Power mode encodings
   localparam logic [1:0] ACD_PM_NORMAL = 2'h3;
   localparam logic [1:0] ACD_PM_SHUTDOWN = 2'h2;
   localparam logic [1:0] ACD_PM_AUTO = 2'h1;
   localparam logic [1:0] ACD_PM_INVALID = 2'h0;
   // Wake-up time after shutdown
   localparam int unsigned ACD_WAKE_NS = 1000;
   localparam int unsigned ACD_CLK_NS = 25;
   localparam int unsigned ACD_WAKE_CYC = (ACD_WAKE_NS + ACD_CLK_NS - 1) / ACD_CLK_NS;
   // Sequencer modes
   typedef enum logic [1:0] {
      ACD_SEQ_OFF,
      ACD_SEQ_PROGRAM_MASK,
      ACD_SEQ_KEEP_RUNNING,
      ACD_SEQ_CONSECUTIVE
   } acd_seq_mode_t;
endpackage

// file: core/acd_sync.sv
// Two-flop synchroniser for single-bit levels
`timescale 1ns/1ps
`default_nettype none
module acd_sync
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Level in and out
   input wire logic d_i,
   output logic q_o
);
   logic meta_r;
   logic q_r;

   // First flop feeds only the second
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         meta_r <= 1'b0;
         q_r <= 1'b0;
      end
      else
      begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule
`default_nettype wire

// file: core/acd_shift.sv
// Serial capture of the configuration word on the link clock
`timescale 1ns/1ps
`default_nettype none
module acd_shift
   import acd_pkg::*;
(
   // Link side
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   // Captured word, stable while done toggle is seen
   output logic [ACD_WORD_BITS-1:0] word_o,
   output logic done_tgl_o
);
   logic [4:0] edge_cnt_r;
   logic [ACD_WORD_BITS-1:0] shift_r;
   logic [ACD_WORD_BITS-1:0] word_r;
   // Link side has no reset, so the toggle starts from a known level
   logic done_tgl_r = 1'b0;
   wire load_edge = (edge_cnt_r < ACD_LAST_LOAD_EDGE);
   wire last_edge = (edge_cnt_r == ACD_FRAME_EDGES_5 - 5'h01);

   // Counter clears while chip select is high; link clock may stop between frames
   always_ff @(negedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         edge_cnt_r <= 5'h00;
      else if (edge_cnt_r != ACD_FRAME_EDGES_5)
         edge_cnt_r <= edge_cnt_r + 5'h01;
   end

   // MSB first, only the first twelve edges shift data
   always_ff @(negedge sclk_i)
   begin
      if (!cs_n_i && load_edge)
         shift_r <= {shift_r[ACD_WORD_BITS-2:0], din_i};
   end

   // Word handed over only at the sixteenth edge, so short frames are dropped
   always_ff @(negedge sclk_i)
   begin
      if (!cs_n_i && last_edge)
      begin
         word_r <= shift_r;
         done_tgl_r <= ~done_tgl_r;
      end
   end

   assign word_o = word_r;
   assign done_tgl_o = done_tgl_r;
endmodule
`default_nettype wire

// file: core/acd_config_decode.sv
// Converter configuration word capture and decode
// Contract
// - Bits five and four choose power mode
// - Mode 11 keeps device fully powered
// - Mode 10 shuts down until changed
// - Mode 01 shuts down after each conversion
// - Bit three with sequencer enable steers sequencing
// - Range bit: 0 double span, 1 single
// - Coding bit: 0 twos complement, 1 binary
// - Channel field decodes unsigned to input 0-7
// - Four sequencer modes from two bits
// - MSB one loads word, else unchanged
// - MSB first, falling edges, twelve of sixteen
// - Sequencing off uses last written channel
`timescale 1ns/1ps
`default_nettype none
module acd_config_decode
   import acd_pkg::*;
(
   // System clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Serial link
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   // Conversion end marker from the analog core
   input wire logic conv_done_i,
   // Applied power state
   output logic [1:0] power_mode_o,
   output logic powered_o,
   output logic awake_o,
   // Applied conversion settings
   output logic range_single_o,
   output logic coding_binary_o,
   output logic [2:0] chan_sel_o,
   output logic [7:0] chan_onehot_o,
   // Sequencer control
   output logic sequencer_enable_o,
   output logic mask_sel_o,
   output acd_seq_mode_t seq_mode_o,
   output logic mask_load_armed_o,
   // Word applied pulse
   output logic word_applied_o
);
   logic [ACD_WORD_BITS-1:0] link_word;
   logic link_tgl;
   logic tgl_s;
   logic tgl_d_r;
   logic [1:0] pm_r;
   logic [1:0] pm_nxt;
   logic range_r;
   logic coding_r;
   logic [2:0] chan_r;
   logic seq_en_r;
   logic mask_sel_r;
   logic asleep_r;
   logic asleep_nxt;
   logic [7:0] wake_cnt_r;
   logic [7:0] wake_cnt_nxt;
   logic applied_r;
   logic [1:0] settle_r;

   // Link-domain capture
   acd_shift u_shift
   (
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .din_i(din_i),
      .word_o(link_word),
      .done_tgl_o(link_tgl)
   );

   // Toggle crossing; word is stable long after the toggle settles
   acd_sync u_sync
   (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(link_tgl),
      .q_o(tgl_s)
   );

   // Decoded fields of the incoming word
   // Events wait until the synchroniser has flushed after reset; a toggle
   // left high by the link would otherwise replay the old word
   wire sync_ready = (settle_r == 2'h3);
   wire word_evt = (tgl_s ^ tgl_d_r) && sync_ready;
   wire write_en = link_word[ACD_BIT_WRITE];
   wire take = word_evt && write_en;
   wire [1:0] pm_new = link_word[ACD_BIT_PM_HI:ACD_BIT_PM_LO];
   wire pm_valid = (pm_new != ACD_PM_INVALID);
   wire [2:0] chan_new = link_word[ACD_BIT_ADDR_HI:ACD_BIT_ADDR_LO];

   // Power mode update; invalid code ignored
   always_comb
   begin
      pm_nxt = pm_r;
      if (take && pm_valid)
         pm_nxt = pm_new;
   end

   // Sleep tracking: shutdown holds, auto sleeps after conversions
   // Any finished frame wakes auto mode, even a no-write one, unless conv_done_i comes in the same cycle; the host
   // must still wait out the wake-up window before a valid conversion
   always_comb
   begin
      asleep_nxt = asleep_r;
      case (pm_nxt)
         ACD_PM_NORMAL: asleep_nxt = 1'b0;
         ACD_PM_SHUTDOWN: asleep_nxt = 1'b1;
         ACD_PM_AUTO:
         begin
            if (conv_done_i)
               asleep_nxt = 1'b1;
            else if (word_evt)
               asleep_nxt = 1'b0;
         end
         default: asleep_nxt = asleep_r;
      endcase
   end

   // Wake-up counter gives the host's settling window a visible flag
   always_comb
   begin
      wake_cnt_nxt = wake_cnt_r;
      if (asleep_nxt)
         wake_cnt_nxt = 8'(ACD_WAKE_CYC);
      else if (wake_cnt_r != 8'h00)
         wake_cnt_nxt = wake_cnt_r - 8'h01;
   end

   // Applied configuration state
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         tgl_d_r <= 1'b0;
         pm_r <= ACD_PM_RESET;
         range_r <= ACD_RANGE_RESET;
         coding_r <= ACD_CODING_RESET;
         chan_r <= ACD_CHAN_RESET;
         {seq_en_r, mask_sel_r} <= ACD_SEQ_RESET;
         asleep_r <= 1'b0;
         wake_cnt_r <= 8'h00;
         applied_r <= 1'b0;
         settle_r <= 2'h0;
      end
      else
      begin
         tgl_d_r <= tgl_s;
         pm_r <= pm_nxt;
         asleep_r <= asleep_nxt;
         wake_cnt_r <= wake_cnt_nxt;
         applied_r <= take;
         if (!sync_ready)
            settle_r <= settle_r + 2'h1;
         if (take)
         begin
            range_r <= link_word[ACD_BIT_RANGE];
            coding_r <= link_word[ACD_BIT_CODING];
            chan_r <= chan_new;
            seq_en_r <= link_word[ACD_BIT_SEQ];
            mask_sel_r <= link_word[ACD_BIT_MASK_SEL];
         end
      end
   end

   // One-hot input select
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_onehot
         assign chan_onehot_o[g] = (chan_r == 3'(g));
      end
   endgenerate

   // Sequencer mode from the two bits
   assign seq_mode_o = acd_seq_mode_t'({seq_en_r, mask_sel_r});
   assign mask_load_armed_o = (seq_mode_o == ACD_SEQ_PROGRAM_MASK);

   // Outputs
   assign power_mode_o = pm_r;
   assign powered_o = !asleep_r;
   assign awake_o = !asleep_r && (wake_cnt_r == 8'h00);
   assign range_single_o = range_r;
   assign coding_binary_o = coding_r;
   assign chan_sel_o = chan_r;
   assign sequencer_enable_o = seq_en_r;
   assign mask_sel_o = mask_sel_r;
   assign word_applied_o = applied_r;

   // Checks
   property p_pm_valid;
      @(posedge clk_i) disable iff (reset_i) pm_r != ACD_PM_INVALID;
   endproperty
   a_pm_valid: assert property (p_pm_valid) else $error("power mode invalid");

   property p_normal_on;
      @(posedge clk_i) disable iff (reset_i) (pm_r == ACD_PM_NORMAL) |-> powered_o;
   endproperty
   a_normal_on: assert property (p_normal_on) else $error("normal mode not powered");

   property p_shut_off;
      @(posedge clk_i) disable iff (reset_i) (pm_r == ACD_PM_SHUTDOWN) |-> !powered_o;
   endproperty
   a_shut_off: assert property (p_shut_off) else $error("shutdown yet powered");

   property p_auto_sleep;
      @(posedge clk_i) disable iff (reset_i)
         (pm_nxt == ACD_PM_AUTO && conv_done_i) |=> !powered_o;
   endproperty
   a_auto_sleep: assert property (p_auto_sleep) else $error("auto mode stayed up");

   property p_nowrite_hold;
      @(posedge clk_i) disable iff (reset_i)
         (word_evt && !write_en) |=> $stable(chan_r) && $stable(range_r);
   endproperty
   a_nowrite_hold: assert property (p_nowrite_hold) else $error("word loaded w/o write");

   property p_chan_load;
      @(posedge clk_i) disable iff (reset_i) take |=> chan_r == $past(chan_new);
   endproperty
   a_chan_load: assert property (p_chan_load) else $error("channel not loaded");

   property p_range_load;
      @(posedge clk_i) disable iff (reset_i)
         take |=> range_single_o == $past(link_word[ACD_BIT_RANGE])
            && coding_binary_o == $past(link_word[ACD_BIT_CODING]);
   endproperty
   a_range_load: assert property (p_range_load) else $error("range/coding wrong");

   property p_onehot;
      @(posedge clk_i) disable iff (reset_i) chan_onehot_o == (8'h01 << chan_r);
   endproperty
   a_onehot: assert property (p_onehot) else $error("onehot mismatch");

   property p_only_on_frame;
      @(posedge clk_i) disable iff (reset_i) !word_evt |=> $stable(seq_mode_o);
   endproperty
   a_only_on_frame: assert property (p_only_on_frame) else $error("mode moved mid frame");

   property p_wake;
      @(posedge clk_i) disable iff (reset_i) $rose(powered_o) |-> !awake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("awake without wait");

   // Field loads and holds around the word strobe
   property p_pm_load;
      @(posedge clk_i) disable iff (reset_i)
         (take && pm_valid) |=> power_mode_o == $past(pm_new);
   endproperty
   a_pm_load: assert property (p_pm_load) else $error("power mode not loaded");

   property p_pm_keep;
      @(posedge clk_i) disable iff (reset_i) (take && !pm_valid) |=> $stable(power_mode_o);
   endproperty
   a_pm_keep: assert property (p_pm_keep) else $error("invalid power code applied");

   property p_seq_load;
      @(posedge clk_i) disable iff (reset_i)
         take |=> sequencer_enable_o == $past(link_word[ACD_BIT_SEQ])
            && mask_sel_o == $past(link_word[ACD_BIT_MASK_SEL]);
   endproperty
   a_seq_load: assert property (p_seq_load) else $error("sequencer bits not loaded");

   property p_hold_between;
      @(posedge clk_i) disable iff (reset_i)
         !take |=> $stable(chan_sel_o) && $stable(range_single_o) && $stable(coding_binary_o);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("field moved w/o word");

   property p_applied;
      @(posedge clk_i) disable iff (reset_i) take |=> word_applied_o;
   endproperty
   a_applied: assert property (p_applied) else $error("applied pulse missing");

   property p_seq_arm;
      @(posedge clk_i) disable iff (reset_i)
         mask_load_armed_o |-> !sequencer_enable_o && mask_sel_o;
   endproperty
   a_seq_arm: assert property (p_seq_arm) else $error("mask load armed wrongly");

   // Wake-up window seen through the powered level, not the counter itself
   property p_wake_span;
      @(posedge clk_i) disable iff (reset_i)
         $rose(awake_o) |-> $past(powered_o, ACD_WAKE_CYC - 1);
   endproperty
   a_wake_span: assert property (p_wake_span) else $error("wake window too short");

   property p_auto_wake;
      @(posedge clk_i) disable iff (reset_i)
         (pm_nxt == ACD_PM_AUTO && word_evt && !conv_done_i) |=> powered_o;
   endproperty
   a_auto_wake: assert property (p_auto_wake) else $error("auto mode did not wake");

   c_write: cover property (@(posedge clk_i) take);
   c_auto: cover property (@(posedge clk_i) pm_r == ACD_PM_AUTO && conv_done_i);
   c_mask: cover property (@(posedge clk_i) mask_load_armed_o);
   c_consec: cover property (@(posedge clk_i) seq_mode_o == ACD_SEQ_CONSECUTIVE);
   c_invalid: cover property (@(posedge clk_i) take && !pm_valid);
endmodule
`default_nettype wire

// file: testbench/acd_host_model.sv
// Host serial port model that shifts configuration frames into the block
`timescale 1ns/1ps
`default_nettype none
module acd_host_model
(
   // Frame request from the bench
   input wire logic req_tgl_i,
   input wire logic [15:0] frame_i,
   input wire logic [4:0] edges_i,
   // Serial link
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   // Frame finished
   output logic done_tgl_o
);
   // Clock idles high and stands still between frames
   initial
   begin
      sclk_o = 1'b1;
      cs_n_o = 1'b0;
      din_o = 1'b0;
      done_tgl_o = 1'b0;
      // A select rise before the first frame clears the device's edge count
      #1 cs_n_o = 1'b1;
      forever
      begin
         @(req_tgl_i);
         #3 cs_n_o = 1'b0;
         // Data moves after a rising edge, sampled on the falling one
         for (int i = 0; i < int'(edges_i); i++)
         begin
            din_o = frame_i[15-i];
            #6 sclk_o = 1'b0;
            #6 sclk_o = 1'b1;
         end
         // Released line shows the inverse, never a stale bit
         #6 din_o = ~din_o;
         cs_n_o = 1'b1;
         #6 done_tgl_o = ~done_tgl_o;
      end
   end
endmodule
`default_nettype wire

// file: testbench/acd_config_decode_tb.sv
// Self-checking testbench for the configuration word decode block
`timescale 1ns/1ps
`default_nettype none
module acd_config_decode_tb
   import acd_pkg::*;
;
   logic clk_i, reset_i, conv_done_i, req, sclk, cs_n, din, done;
   logic [15:0] frame_w;
   logic [4:0] edges;
   logic [1:0] pm;
   logic pwr, awk, rng, cod, seqe, msk, armed, appl;
   logic [2:0] ch;
   logic [7:0] oh;
   acd_seq_mode_t sm;
   int fails, comparisons, applied, cyc;

   acd_config_decode u_acd_config_decode (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk),
      .cs_n_i(cs_n), .din_i(din), .conv_done_i(conv_done_i), .power_mode_o(pm),
      .powered_o(pwr), .awake_o(awk), .range_single_o(rng), .coding_binary_o(cod),
      .chan_sel_o(ch), .chan_onehot_o(oh), .sequencer_enable_o(seqe), .mask_sel_o(msk),
      .seq_mode_o(sm), .mask_load_armed_o(armed), .word_applied_o(appl));
   acd_host_model u_acd_host_model (.req_tgl_i(req), .frame_i(frame_w), .edges_i(edges),
      .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .done_tgl_o(done));

   // System clock
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Count applied pulses and cut a hang short
   always @(posedge clk_i)
   begin
      if (appl === 1'b1)
         applied++;
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One frame; inc is how many applied pulses should follow
   task automatic xfer(input logic [11:0] w, input logic [4:0] n, input int inc);
      int base;
      int k;
      logic d0;
      base = applied;
      k = 0;
      @(posedge clk_i);
      d0 = done;
      frame_w <= {w, 4'h0};
      edges <= n;
      req <= ~req;
      while (done === d0 && k < 60)
      begin
         @(posedge clk_i);
         k++;
      end
      repeat (8) @(posedge clk_i);
      #1;
      cmp(16'(applied - base), 16'(inc), "applied");
   endtask

   task automatic wr(input logic s, input logic [2:0] c, input logic [1:0] p,
      input logic m, input logic r, input logic cd);
      xfer({1'b1, s, 1'b0, c, p, m, 1'b0, r, cd}, ACD_FRAME_EDGES_5, 1);
   endtask

   task automatic conv;
      @(posedge clk_i);
      conv_done_i <= 1'b1;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   task automatic t_reset;
      cmp(16'({pm, pwr, awk, rng, cod, ch, seqe, msk}), 16'({ACD_PM_RESET, 2'h3,
         ACD_RANGE_RESET, ACD_CODING_RESET, ACD_CHAN_RESET, ACD_SEQ_RESET}), "reset");
   endtask

   task automatic t_chan;
      for (int c = 0; c < 8; c++)
      begin
         wr(1'b0, 3'(c), ACD_PM_NORMAL, 1'b0, 1'b0, 1'b0);
         cmp(16'(ch), 16'(c), "chan");
         cmp(16'(oh), 16'h0001 << c, "onehot");
      end
   endtask

   // Writes that must leave the word untouched
   task automatic t_refuse;
      wr(1'b0, 3'h5, ACD_PM_NORMAL, 1'b0, 1'b0, 1'b0);
      xfer(12'h7ff, ACD_FRAME_EDGES_5, 0);
      cmp(16'(ch), 16'h0005, "no write bit");
      xfer(12'h8b0, ACD_LAST_LOAD_EDGE, 0);
      cmp(16'(ch), 16'h0005, "short frame");
   endtask

   task automatic t_rc;
      for (int i = 0; i < 4; i++)
      begin
         wr(1'b0, 3'h0, ACD_PM_NORMAL, 1'b0, i[1], i[0]);
         cmp(16'({rng, cod}), 16'(i), "range coding");
      end
   endtask

   // Deliberate 00 power write to see the previous mode kept
   task automatic t_pwr;
      wr(1'b0, 3'h1, ACD_PM_SHUTDOWN, 1'b0, 1'b0, 1'b0);
      cmp(16'({pm, pwr}), 16'({ACD_PM_SHUTDOWN, 1'b0}), "shutdown");
      conv();
      cmp(16'(pwr), 16'h0000, "stays down");
      wr(1'b0, 3'h4, ACD_PM_INVALID, 1'b0, 1'b0, 1'b0);
      cmp(16'({pm, ch}), 16'({ACD_PM_SHUTDOWN, 3'h4}), "invalid");
      wr(1'b0, 3'h0, ACD_PM_NORMAL, 1'b0, 1'b0, 1'b0);
      cmp(16'({pm, pwr}), 16'({ACD_PM_NORMAL, 1'b1}), "normal");
   endtask

   task automatic t_auto;
      wr(1'b0, 3'h0, ACD_PM_AUTO, 1'b0, 1'b0, 1'b0);
      cmp(16'({pm, pwr}), 16'({ACD_PM_AUTO, 1'b1}), "auto");
      conv();
      cmp(16'(pwr), 16'h0000, "auto down");
      wr(1'b0, 3'h0, ACD_PM_AUTO, 1'b0, 1'b0, 1'b0);
      cmp(16'({pwr, awk}), 16'h0002, "waking");
      repeat (ACD_WAKE_CYC) @(posedge clk_i);
      #1;
      cmp(16'(awk), 16'h0001, "awake");
   endtask

   // Order 00,10,11,01 so the mask-programming mode comes last
   task automatic t_seq;
      logic [1:0] m;
      for (int k = 0; k < 4; k++)
      begin
         m = 2'(8'h78 >> (2 * k));
         wr(m[1], 3'h6, ACD_PM_NORMAL, m[0], 1'b0, 1'b0);
         cmp(16'(sm), 16'(m), "seq mode");
         cmp(16'({seqe, msk, armed}), 16'({m, m == 2'h1}), "seq bits");
         cmp(16'(ch), 16'h0006, "seq chan");
      end
   endtask

   // Mid-run reset with the link toggle left high: nothing may be replayed
   task automatic t_rerun;
      int base;
      base = applied;
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      t_reset();
      cmp(16'(applied - base), 16'h0000, "replay");
      wr(1'b0, 3'h3, ACD_PM_NORMAL, 1'b0, 1'b0, 1'b0);
      cmp(16'(ch), 16'h0003, "after reset");
   endtask

   task automatic tally_and_finish;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      reset_i = 1'b1;
      conv_done_i = 1'b0;
      req = 1'b0;
      frame_w = 16'h0000;
      edges = 5'h10;
      fails = 0;
      comparisons = 0;
      applied = 0;
      cyc = 0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      #1;
      t_reset();
      t_chan();
      t_refuse();
      t_rc();
      t_pwr();
      t_auto();
      t_seq();
      t_rerun();
      tally_and_finish();
   end
endmodule
`default_nettype wire
